/* File: pkg/osc_defs.vh */
// constants for the output sync controller
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH

// register byte offsets
`define OSC_ADDR_SYNC 5'h00
`define OSC_ADDR_WIN 5'h04
`define OSC_ADDR_CFG 5'h08
`define OSC_ADDR_CMD 5'h0C
`define OSC_ADDR_STAT 5'h10
`define OSC_ADDR_APPL 5'h14

// sync register fields
`define OSC_DLY_LSB 0
`define OSC_DLY_MSB 5
`define OSC_PER_LSB 6
`define OSC_PER_MSB 9
`define OSC_SCALE_BIT 9
`define OSC_RESYNC_BIT 10

// window register fields
`define OSC_OPEN_LSB 0
`define OSC_OPEN_MSB 4
`define OSC_CLOSE_LSB 5
`define OSC_CLOSE_MSB 9

// config and status fields
`define OSC_SEL_BIT 0
`define OSC_STAT_CLKF 0
`define OSC_STAT_SYNCF 1
`define OSC_STAT_WIN 2
`define OSC_STAT_STRB 3
`define OSC_STAT_CNT_LSB 4
`define OSC_STAT_CNT_MSB 9

// reset values
`define OSC_DLY_RST 6'h00
`define OSC_PER_RST 4'h0
`define OSC_WIN_RST 5'h00
`define OSC_CMD_RST 4'h0

// timing in ns and derived cycle counts
`define OSC_CLK_NS 25
`define OSC_CORE_NS 500
`define OSC_TICK_NS 250000
`define OSC_STAGGER_NS 62500
`define OSC_REF_SLOW_NS 4000
`define OSC_REF_FAST_NS 1000
`define OSC_INT_DIV (`OSC_CORE_NS / `OSC_CLK_NS)
`define OSC_PRESC (`OSC_TICK_NS / `OSC_CORE_NS)
`define OSC_STAGGER_CNT (`OSC_STAGGER_NS / `OSC_CORE_NS)
`define OSC_REF_SLOW_CYC (`OSC_REF_SLOW_NS / `OSC_CLK_NS)
`define OSC_REF_FAST_CYC (`OSC_REF_FAST_NS / `OSC_CLK_NS)
`define OSC_REF_TIMEOUT 8'hFF

`endif

/* File: src/osc_clk_mon.v */
// reference clock monitor and 2 MHz core tick generator
`timescale 1ns/1ps
`include "osc_defs.vh"
module osc_clk_mon (
  input wire clk, // system clock
  input wire nrst, // async reset, active low
  input wire ref_clock_in, // reference clock level
  input wire ref_clock_select, // 1 = 1 MHz, 0 = 250 kHz
  output reg ref_clock_fail, // reference out of range
  output reg core_tick // 2 MHz core tick pulse
);
  localparam integer SLOW_N = `OSC_REF_SLOW_CYC;
  localparam integer FAST_N = `OSC_REF_FAST_CYC;
  localparam integer DIV_N = `OSC_INT_DIV;
  localparam [7:0] SLOW = SLOW_N[7:0];
  localparam [7:0] FAST = FAST_N[7:0];
  localparam [7:0] INT_DIV = DIV_N[7:0];

  reg ref_q;
  reg [7:0] per_cnt_q;
  reg [7:0] period_q;
  reg valid_q;
  reg [7:0] core_cnt_q;
  reg [7:0] div;
  wire ref_rise;
  wire [7:0] per_now;

  // window of +-1/8 around the selected period
  function in_range;
    input [7:0] p;
    input s;
    reg [7:0] e;
    begin
      e = s ? FAST : SLOW;
      in_range = (p >= e - (e >> 3)) && (p <= e + (e >> 3));
    end
  endfunction

  assign ref_rise = ref_clock_in & ~ref_q;
  assign per_now = per_cnt_q + 8'h01;

  // period measurement and failure flag
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q <= 1'b0;
      per_cnt_q <= 8'h00;
      period_q <= 8'h00;
      valid_q <= 1'b0;
      ref_clock_fail <= 1'b0;
    end else begin
      ref_q <= ref_clock_in;
      if (ref_rise) begin
        per_cnt_q <= 8'h00;
        period_q <= per_now;
        valid_q <= 1'b1;
        ref_clock_fail <= !in_range(per_now, ref_clock_select); // RULE2
      end else if (per_cnt_q == `OSC_REF_TIMEOUT) begin
        ref_clock_fail <= 1'b1; // RULE1
      end else begin
        per_cnt_q <= per_now;
      end
    end
  end

  // multiply reference by 8 or 2, fall back to internal divider
  always @* begin
    if (ref_clock_fail || !valid_q)
      div = INT_DIV; // RULE1
    else if (ref_clock_select)
      div = period_q >> 1; // RULE20
    else
      div = period_q >> 3; // RULE20
  end

  // core tick divider
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_cnt_q <= 8'h00;
      core_tick <= 1'b0;
    end else if (core_cnt_q + 8'h01 >= div) begin
      core_cnt_q <= 8'h00;
      core_tick <= 1'b1;
    end else begin
      core_cnt_q <= core_cnt_q + 8'h01;
      core_tick <= 1'b0;
    end
  end
endmodule

/* File: src/osc_stagger.v */
// staggered application of channel commands after the strobe
`timescale 1ns/1ps
`include "osc_defs.vh"
module osc_stagger (
  input wire clk, // system clock
  input wire nrst, // async reset, active low
  input wire core_tick, // 2 MHz core tick
  input wire restart, // resync restart pulse
  input wire apply_evt, // accepted actuation event
  input wire [3:0] commands, // latest commands
  input wire enable, // low forces channel_out off
  output reg [3:0] channel_out, // applied channel states
  output reg [3:0] channel_apply // per channel apply pulse
);
  localparam integer STEP_N = `OSC_STAGGER_CNT - 1;
  localparam [6:0] STEP_LAST = STEP_N[6:0];

  reg [3:0] cmd_q;
  reg [3:0] applied_q;
  reg [3:0] applied_d;
  reg [3:0] pulse_d;
  reg [1:0] stage_q;
  reg busy_q;
  reg [6:0] step_q;
  wire step_done;

  assign step_done = busy_q & core_tick & (step_q == STEP_LAST);

  // channel 0 at the event, others one quarter period apart
  always @* begin
    applied_d = applied_q;
    pulse_d = 4'h0;
    if (!restart && apply_evt) begin
      applied_d[0] = commands[0]; // RULE18
      pulse_d[0] = 1'b1;
    end else if (!restart && step_done) begin
      applied_d[stage_q] = cmd_q[stage_q]; // RULE18
      pulse_d[stage_q] = 1'b1; // RULE18
    end
  end

  // stagger sequencer and output registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= `OSC_CMD_RST;
      applied_q <= `OSC_CMD_RST;
      stage_q <= 2'h0;
      busy_q <= 1'b0;
      step_q <= 7'h00;
      channel_out <= 4'h0;
      channel_apply <= 4'h0;
    end else begin
      if (restart) begin
        busy_q <= 1'b0;
        step_q <= 7'h00;
        stage_q <= 2'h0;
      end else if (apply_evt) begin
        cmd_q <= commands;
        busy_q <= 1'b1;
        stage_q <= 2'h1;
        step_q <= 7'h00;
      end else if (busy_q && core_tick) begin
        if (step_done) begin
          step_q <= 7'h00;
          stage_q <= stage_q + 2'h1;
          if (stage_q == 2'h3)
            busy_q <= 1'b0;
        end else begin
          step_q <= step_q + 7'h01;
        end
      end
      applied_q <= applied_d;
      channel_apply <= pulse_d;
      channel_out <= applied_d & {4{enable}}; // RULE1
    end
  end
endmodule

/* File: src/osc_top.v */
// output sync controller: clock monitor, sync counter, bus slave
// Behaviour
// (RULE1) bad reference: flag, outputs off, internal clock
// (RULE2) flag failure when selected rate mismatches reference
// (RULE3) sync counter steps once per 4 kHz tick
// (RULE4) counter equals delay: raise actuation strobe
// (RULE5) counter wraps at period, strobe cleared
// (RULE6) resync clears counter, window flag, strobe
// (RULE7) window opens and closes at programmed counts
// (RULE8) bad window programming holds window flag set
// (RULE9) sync register access inside window: sync failure
// (RULE10) no traffic between strobes: sync failure
// (RULE11) no strobe or failure: actuation unchanged
// (RULE12) resync bit self clears; clear bit no effect
// (RULE13) host sets resync only when re-initializing
// (RULE14) period field: 4 bits, 1 ms steps
// (RULE15) delay field: 6 bits, 250 us steps
// (RULE16) window steps 250 us, or 500 us with scale
// (RULE17) resync restarts pwm, sync, duration counters
// (RULE18) channels staggered by a quarter period
// (RULE19) host paces cycles near period, delay half
// (RULE20) select bits set the reference multiplier
// (RULE21) 4 kHz tick is core clock divided by 500
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "osc_defs.vh"
module osc_top (
  input wire clk, // 40 MHz system clock
  input wire nrst, // async reset, active low
  input wire [4:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // stall request
  input wire ref_clock_in, // reference clock from host
  output wire [3:0] channel_out, // applied channel states
  output wire [3:0] channel_apply, // per channel apply pulse
  output reg counters_restart, // pwm/duration restart pulse
  output reg actuation_strobe, // actuation strobe level
  output reg tolerance_window_flag, // tolerance window level
  output wire ref_clock_fail, // reference clock failure
  output reg sync_fail // sticky sync failure
);
  localparam integer PRESC_N = `OSC_PRESC - 1;
  localparam [8:0] PRESC_LAST = PRESC_N[8:0];

  // software registers
  reg [5:0] sync_delay_q;
  reg [3:0] cycle_period_q;
  reg resync_request_q;
  reg [4:0] window_open_value_q;
  reg [4:0] window_close_value_q;
  reg ref_clock_select_q;
  reg [3:0] command_q;

  // bus handshake
  reg ack_q;
  wire req;
  wire take;
  wire take_wr;
  wire take_rd;

  // timing state
  wire core_tick;
  reg [8:0] presc_q;
  reg tick_q;
  reg [5:0] sync_cnt_q;
  reg [5:0] cnt_d;
  reg strobe_d;
  reg win_d;
  reg fire;
  reg traffic_q;
  reg armed_q;
  reg sync_fail_d;

  wire [5:0] period_ticks;
  wire [5:0] open_ticks;
  wire [5:0] close_ticks;
  wire bad_window;
  wire sync_access;
  wire apply_evt;

  // window value in counter units, doubled when scaled
  function [5:0] win_ticks;
    input [4:0] v;
    input scale;
    begin
      win_ticks = scale ? {v, 1'b0} : {1'b0, v}; // RULE16
    end
  endfunction

  // one wait cycle per access
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign take = req & ack_q;
  assign take_wr = take & avs_write;
  assign take_rd = take & avs_read;

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // read data prepared during the wait cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= 32'h00000000;
      if (avs_address == `OSC_ADDR_SYNC) begin
        avs_readdata[`OSC_DLY_MSB:`OSC_DLY_LSB] <= sync_delay_q;
        avs_readdata[`OSC_PER_MSB:`OSC_PER_LSB] <= cycle_period_q;
        avs_readdata[`OSC_RESYNC_BIT] <= resync_request_q;
      end else if (avs_address == `OSC_ADDR_WIN) begin
        avs_readdata[`OSC_OPEN_MSB:`OSC_OPEN_LSB] <= window_open_value_q;
        avs_readdata[`OSC_CLOSE_MSB:`OSC_CLOSE_LSB] <=
          window_close_value_q;
      end else if (avs_address == `OSC_ADDR_CFG) begin
        avs_readdata[`OSC_SEL_BIT] <= ref_clock_select_q;
      end else if (avs_address == `OSC_ADDR_CMD) begin
        avs_readdata[3:0] <= command_q;
      end else if (avs_address == `OSC_ADDR_STAT) begin
        avs_readdata[`OSC_STAT_CLKF] <= ref_clock_fail;
        avs_readdata[`OSC_STAT_SYNCF] <= sync_fail;
        avs_readdata[`OSC_STAT_WIN] <= tolerance_window_flag;
        avs_readdata[`OSC_STAT_STRB] <= actuation_strobe;
        avs_readdata[`OSC_STAT_CNT_MSB:`OSC_STAT_CNT_LSB] <= sync_cnt_q;
      end else if (avs_address == `OSC_ADDR_APPL) begin
        avs_readdata[3:0] <= channel_out;
      end
    end
  end

  // register writes; resync bit clears itself one cycle later
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_delay_q <= `OSC_DLY_RST;
      cycle_period_q <= `OSC_PER_RST;
      resync_request_q <= 1'b0;
      window_open_value_q <= `OSC_WIN_RST;
      window_close_value_q <= `OSC_WIN_RST;
      ref_clock_select_q <= 1'b0;
      command_q <= `OSC_CMD_RST;
    end else begin
      if (resync_request_q)
        resync_request_q <= 1'b0; // RULE12
      if (take_wr) begin
        if (avs_address == `OSC_ADDR_SYNC) begin
          sync_delay_q <= avs_writedata[`OSC_DLY_MSB:`OSC_DLY_LSB]; // RULE15
          cycle_period_q <= avs_writedata[`OSC_PER_MSB:`OSC_PER_LSB]; // RULE14
          if (avs_writedata[`OSC_RESYNC_BIT])
            resync_request_q <= 1'b1; // RULE12
        end else if (avs_address == `OSC_ADDR_WIN) begin
          window_open_value_q <= avs_writedata[`OSC_OPEN_MSB:`OSC_OPEN_LSB];
          window_close_value_q <=
            avs_writedata[`OSC_CLOSE_MSB:`OSC_CLOSE_LSB];
        end else if (avs_address == `OSC_ADDR_CFG) begin
          ref_clock_select_q <= avs_writedata[`OSC_SEL_BIT];
        end else if (avs_address == `OSC_ADDR_CMD) begin
          command_q <= avs_writedata[3:0];
        end
      end
    end
  end

  // reference monitor and core clock
  osc_clk_mon u_clk_mon (
    .clk(clk),
    .nrst(nrst),
    .ref_clock_in(ref_clock_in),
    .ref_clock_select(ref_clock_select_q),
    .ref_clock_fail(ref_clock_fail),
    .core_tick(core_tick)
  );

  // 4 kHz tick prescaler, restarted on resync
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      presc_q <= 9'h000;
      tick_q <= 1'b0;
      counters_restart <= 1'b0;
    end else begin
      counters_restart <= resync_request_q; // RULE17
      tick_q <= 1'b0;
      if (resync_request_q) begin
        presc_q <= 9'h000; // RULE21
      end else if (core_tick) begin
        if (presc_q == PRESC_LAST) begin
          presc_q <= 9'h000;
          tick_q <= 1'b1; // RULE21
        end else begin
          presc_q <= presc_q + 9'h001;
        end
      end
    end
  end

  // compare values in counter units
  assign period_ticks = {cycle_period_q, 2'b00}; // RULE14
  assign open_ticks = win_ticks(window_open_value_q,
                                cycle_period_q[3]);
  assign close_ticks = win_ticks(window_close_value_q,
                                 cycle_period_q[3]);
  assign bad_window = (open_ticks >= close_ticks) ||
                      (close_ticks >= period_ticks); // RULE8

  // next state of counter, strobe and window
  always @* begin
    cnt_d = sync_cnt_q;
    strobe_d = actuation_strobe;
    win_d = tolerance_window_flag;
    fire = 1'b0;
    if (resync_request_q) begin
      cnt_d = 6'h00; // RULE6
      strobe_d = 1'b0; // RULE6
      win_d = 1'b0; // RULE6
    end else if (tick_q) begin
      cnt_d = sync_cnt_q + 6'h01; // RULE3
      if (cnt_d >= period_ticks) begin
        cnt_d = 6'h00; // RULE5
        strobe_d = 1'b0; // RULE5
        win_d = 1'b0;
      end
      if (cnt_d == open_ticks)
        win_d = 1'b1; // RULE7
      if (cnt_d == close_ticks)
        win_d = 1'b0; // RULE7
      if (cnt_d == sync_delay_q && !actuation_strobe) begin
        strobe_d = 1'b1; // RULE4
        fire = 1'b1; // RULE4
      end
    end
    if (bad_window)
      win_d = 1'b1; // RULE8
  end

  // synchronization counter and flags
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_cnt_q <= 6'h00;
      actuation_strobe <= 1'b0;
      tolerance_window_flag <= 1'b0;
    end else begin
      sync_cnt_q <= cnt_d;
      actuation_strobe <= strobe_d;
      tolerance_window_flag <= win_d;
    end
  end

  assign sync_access = take && (avs_address == `OSC_ADDR_SYNC);

  // sync failure sources; a new failure beats a status read
  always @* begin
    sync_fail_d = sync_fail;
    if (take_rd && avs_address == `OSC_ADDR_STAT)
      sync_fail_d = 1'b0;
    if (sync_access && tolerance_window_flag)
      sync_fail_d = 1'b1; // RULE9
    if (fire && armed_q && !traffic_q && !take)
      sync_fail_d = 1'b1; // RULE10
  end

  // traffic tracking between strobes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      traffic_q <= 1'b0;
      armed_q <= 1'b0;
      sync_fail <= 1'b0;
    end else begin
      sync_fail <= sync_fail_d;
      if (resync_request_q) begin
        armed_q <= 1'b0;
        traffic_q <= take;
      end else if (fire) begin
        armed_q <= 1'b1; // RULE10
        traffic_q <= take;
      end else if (take) begin
        traffic_q <= 1'b1; // RULE10
      end
    end
  end

  // commands apply only on a strobe without sync failure
  assign apply_evt = fire & ~sync_fail_d; // RULE11

  osc_stagger u_stagger (
    .clk(clk),
    .nrst(nrst),
    .core_tick(core_tick),
    .restart(counters_restart),
    .apply_evt(apply_evt),
    .commands(command_q),
    .enable(~ref_clock_fail),
    .channel_out(channel_out),
    .channel_apply(channel_apply)
  );
endmodule

/* File: test/osc_props.sv */
// assertion checker for the output sync controller ports
`timescale 1ns/1ps
module osc_props (
  input wire clk, // system clock
  input wire nrst, // async reset, active low
  input wire [4:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire avs_waitrequest, // stall request
  input wire [3:0] channel_out, // applied states
  input wire [3:0] channel_apply, // apply pulses
  input wire counters_restart, // restart pulse
  input wire actuation_strobe, // strobe level
  input wire tolerance_window_flag, // window level
  input wire ref_clock_fail, // clock failure
  input wire sync_fail // sticky sync failure
);
  reg [12:0] gap_q;
  wire take = (avs_read || avs_write) && avs_waitrequest == 1'b0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // cycles since channel 0 was applied, saturating
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      gap_q <= 13'h0000;
    else if (channel_apply[0])
      gap_q <= 13'h0001;
    else if (gap_q != 13'h1FFF)
      gap_q <= gap_q + 13'h0001;
  end
  property p_fail_off;
    ref_clock_fail && $past(ref_clock_fail) |-> channel_out == 4'h0;
  endproperty
  a_fail_off: assert property (p_fail_off)
    else $error("outputs active during clock failure");
  property p_apply_start;
    $rose(actuation_strobe) && !sync_fail && !$past(sync_fail)
      && !ref_clock_fail |-> ##[0:2] channel_apply[0];
  endproperty
  a_apply_start: assert property (p_apply_start)
    else $error("strobe did not apply channel 0");
  property p_apply_in_strobe;
    channel_apply[0] |-> actuation_strobe;
  endproperty
  a_apply_in_strobe: assert property (p_apply_in_strobe)
    else $error("channel applied without strobe");
  property p_stagger;
    channel_apply[1] |-> gap_q >= 13'h09B0 && gap_q <= 13'h09D8;
  endproperty
  a_stagger: assert property (p_stagger)
    else $error("channel 1 not a quarter period after channel 0");
  property p_restart_clear;
    counters_restart |=> !actuation_strobe [*8];
  endproperty
  a_restart_clear: assert property (p_restart_clear)
    else $error("strobe survived a resync");
  property p_resync;
    take && avs_write && avs_address == 5'h00
      |-> ##2 (counters_restart == $past(avs_writedata[10], 2));
  endproperty
  a_resync: assert property (p_resync)
    else $error("restart pulse does not follow resync bit");
  property p_win_access;
    take && avs_address == 5'h00 && tolerance_window_flag |=> sync_fail;
  endproperty
  a_win_access: assert property (p_win_access)
    else $error("sync access in window not flagged");
  property p_fail_sticky;
    sync_fail && !(take && avs_read && avs_address == 5'h10) |=> sync_fail;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky)
    else $error("sync failure lost before status read");
endmodule
bind osc_top osc_props u_props (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .channel_out(channel_out), .channel_apply(channel_apply),
  .counters_restart(counters_restart), .actuation_strobe(actuation_strobe),
  .tolerance_window_flag(tolerance_window_flag),
  .ref_clock_fail(ref_clock_fail), .sync_fail(sync_fail));

/* File: test/osc_host_model.sv */
// host side reference clock source
`timescale 1ns/1ps
module osc_host_model (
  input wire clk, // system clock
  input wire run, // clock enabled
  input wire fast, // 1 MHz when set, else 250 kHz
  output reg ref_clock_in // reference clock to device
);
  reg [7:0] cnt_q;
  initial begin
    cnt_q = 8'h00;
    ref_clock_in = 1'b0;
  end
  // free running divider, parks low when stopped
  always @(posedge clk) begin
    if (!run) begin
      cnt_q <= 8'h00;
      ref_clock_in <= 1'b0;
    end else if (cnt_q >= (fast ? 8'h13 : 8'h4F)) begin
      cnt_q <= 8'h00;
      ref_clock_in <= ~ref_clock_in;
    end else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule

/* File: test/output_sync_controller_tb.sv */
// self-checking bench for the output sync controller
`timescale 1ns/1ps
`include "osc_defs.vh"
module output_sync_controller_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [4:0] avs_address = 5'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg run = 1'b1;
  reg fast = 1'b0;
  reg [31:0] rd;
  wire [31:0] avs_readdata;
  wire [3:0] channel_out, channel_apply;
  wire avs_waitrequest, ref_clock_in, counters_restart, actuation_strobe;
  wire tolerance_window_flag, ref_clock_fail, sync_fail;
  integer miscompares = 0;
  integer tests_run = 0;
  integer i;
  integer tw [0:3];
  // run, fast, select, expected failure per clock case
  localparam [23:0] CK = 24'h8BED18;
  always #12.5 clk = ~clk;
  osc_top u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ref_clock_in(ref_clock_in),
    .channel_out(channel_out), .channel_apply(channel_apply),
    .counters_restart(counters_restart),
    .actuation_strobe(actuation_strobe),
    .tolerance_window_flag(tolerance_window_flag),
    .ref_clock_fail(ref_clock_fail), .sync_fail(sync_fail));
  osc_host_model u_host (.clk(clk), .run(run), .fast(fast),
    .ref_clock_in(ref_clock_in));
  task print_verdict;
    begin
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task tmo;
    begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: wait ran out", $time);
      print_verdict;
    end
  endtask
  // one bus access, held until waitrequest is low at a rising edge
  task bus(input wr, input [4:0] a, input [31:0] d);
    integer n;
    reg w;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      w = 1'b1;
      while (w !== 1'b0) begin
        @(posedge clk);
        w = avs_waitrequest;
        rd = avs_readdata;
        n = n + 1;
        if (n > 20)
          tmo;
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk(n, 2);
      @(posedge clk);
    end
  endtask
  // wait for window (win=1) or strobe to reach level v
  task wait_lvl(input win, input v);
    integer t;
    begin
      t = 0;
      @(negedge clk);
      while ((win ? tolerance_window_flag : actuation_strobe) !== v) begin
        @(negedge clk);
        t = t + 1;
        if (t > 45000)
          tmo;
      end
      @(posedge clk);
    end
  endtask
  // reset values, read-only and unmapped places
  task s_regs;
    begin
      bus(1, `OSC_ADDR_APPL, 32'hF);
      bus(1, 5'h18, 32'hF);
      for (i = 0; i < 8; i = i + 1) begin
        bus(0, {i[2:0], 2'b00}, 32'h0);
        chk(i == 4 ? rd & 32'hFFFE : rd, i == 4 ? 6 : 0);
      end
      bus(1, `OSC_ADDR_SYNC, 32'h42);
      bus(0, `OSC_ADDR_SYNC, 32'h0);
      chk(rd, 32'h42);
    end
  endtask
  // reference rate against selected rate
  task s_clock;
    reg [3:0] c;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        c = CK[23 - 4 * i -: 4];
        run <= c[3];
        fast <= c[2];
        bus(1, `OSC_ADDR_CFG, {31'h0, c[1]});
        repeat (700) @(posedge clk);
        bus(0, `OSC_ADDR_STAT, 32'h0);
        chk(rd[`OSC_STAT_CLKF], c[0]);
        chk(channel_out, 0);
      end
    end
  endtask
  // one full cycle: window, strobe, wrap and stagger
  task s_sync;
    integer t;
    begin
      bus(1, `OSC_ADDR_WIN, 32'h61);
      bus(1, `OSC_ADDR_CMD, 32'hA);
      bus(1, `OSC_ADDR_SYNC, 32'h442);
      bus(0, `OSC_ADDR_STAT, 32'h0);
      for (i = 0; i < 4; i = i + 1)
        tw[i] = 0;
      for (t = 1; t < 41000; t = t + 1) begin
        @(negedge clk);
        if (t > 8 && tolerance_window_flag && tw[0] == 0)
          tw[0] = t;
        if (actuation_strobe && tw[1] == 0)
          tw[1] = t;
        if (!tolerance_window_flag && tw[0] != 0 && tw[2] == 0)
          tw[2] = t;
        if (!actuation_strobe && tw[1] != 0 && tw[3] == 0)
          tw[3] = t;
      end
      for (i = 0; i < 4; i = i + 1)
        chk((tw[i] + 5000) / 10000, i + 1);
      chk(channel_out, 4'hA);
      @(posedge clk);
    end
  endtask
  // no traffic between two strobes
  task s_idle;
    begin
      wait_lvl(0, 1);
      bus(0, `OSC_ADDR_STAT, 32'h0);
      chk(rd[`OSC_STAT_SYNCF], 1);
      chk(rd[`OSC_STAT_STRB], 1);
    end
  endtask
  // resync mid-cycle, then access inside the window
  task s_resync;
    begin
      bus(1, `OSC_ADDR_SYNC, 32'h442);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(actuation_strobe, 0);
      chk(tolerance_window_flag, 0);
      @(posedge clk);
      bus(0, `OSC_ADDR_STAT, 32'h0);
      chk(rd[`OSC_STAT_SYNCF], 1);
      bus(0, `OSC_ADDR_SYNC, 32'h0);
      chk(rd, 32'h42);
      wait_lvl(1, 1);
      bus(1, `OSC_ADDR_CMD, 32'h5);
      bus(0, `OSC_ADDR_SYNC, 32'h0);
      wait_lvl(0, 1);
      repeat (8000) @(posedge clk);
      @(negedge clk);
      chk(channel_out, 4'hA);
      @(posedge clk);
      bus(0, `OSC_ADDR_STAT, 32'h0);
      chk(rd[`OSC_STAT_SYNCF], 1);
    end
  endtask
  // scaled window bound, then outputs off on a lost reference
  task s_fail;
    begin
      bus(1, `OSC_ADDR_SYNC, 32'h602);
      bus(1, `OSC_ADDR_WIN, 32'h221);
      bus(0, `OSC_ADDR_STAT, 32'h0);
      chk(rd[`OSC_STAT_WIN], 1);
      run <= 1'b0;
      repeat (300) @(negedge clk);
      chk(ref_clock_fail, 1);
      chk(channel_out, 4'h0);
      @(posedge clk);
    end
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    s_regs;
    s_clock;
    s_sync;
    s_idle;
    s_resync;
    s_fail;
    print_verdict;
  end
endmodule
